// File: pkg/flm_pkg.sv
// Shared constants and types for the loop modem
package flm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and tone timing
  localparam longint CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam longint MARK_HZ = 1200;
  localparam longint SPACE_HZ = 2200;
  localparam int BAUD_BPS = 1200;
  localparam int SLOT_US = 833;
  localparam int PHASE_W = 24;
  localparam logic [23:0] INC_MARK = 24'((MARK_HZ << PHASE_W) / CLK_HZ);
  localparam logic [23:0] INC_SPACE = 24'((SPACE_HZ << PHASE_W) / CLK_HZ);

  ////////////////////////////////////////////////////////////////////////////
  // Receive sampling
  localparam longint SAMPLE_HZ = 76_800;
  localparam logic [10:0] SAMPLE_DIV = 11'(CLK_HZ / SAMPLE_HZ);
  localparam int ADC_W = 10;
  localparam int DAC_W = 8;
  localparam logic [9:0] ADC_MID = 10'h200;
  localparam logic [9:0] ZC_HYST = 10'h004;
  localparam logic [6:0] HALF_MARK = 7'(SAMPLE_HZ / (2 * MARK_HZ));
  localparam logic [6:0] HALF_SPACE = 7'(SAMPLE_HZ / (2 * SPACE_HZ));
  localparam logic [6:0] BIT_SPLIT = 7'((HALF_MARK + HALF_SPACE) / 2);
  localparam logic [6:0] RUN_MAX = 7'h7F;
  localparam logic [5:0] CD_WIN = 6'(SAMPLE_HZ / MARK_HZ - 1);
  localparam int ADC_FS_MV = 1230;
  localparam int CD_ON_MV = 120;
  localparam int CD_OFF_MV = 80;
  localparam logic [9:0] CD_ON_CNT = 10'((CD_ON_MV * 1024) / ADC_FS_MV);
  localparam logic [9:0] CD_OFF_CNT = 10'((CD_OFF_MV * 1024) / ADC_FS_MV);
  localparam logic [DAC_W-1:0] DAC_MID = 8'h80;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin stretch
  localparam int RST_HOLD_NS = 10_000;
  localparam logic [9:0] RST_HOLD_CYC = 10'(RST_HOLD_NS / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_STATE = 8'h0C;
  localparam int CTRL_SOFT_RST = 0;
  localparam int CTRL_MUTE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int EV_CD_ON = 0;
  localparam int EV_CD_OFF = 1;
  localparam int EV_RX_EDGE = 2;
  localparam int EV_MODE = 3;
  localparam int EV_PIN_RST = 4;
  localparam int EV_N = 5;
  localparam logic [4:0] MASK_RESET = 5'h00;

  // Register bus request bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } flm_bus_req_t;

endpackage

// File: rtl/flm_tone_gen.sv
// Phase-continuous sine tone generator
`timescale 1ns/10ps
module flm_tone_gen (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic mark,
  output logic [7:0] dac_code
);

  logic [23:0] phase_ff;
  logic [23:0] inc;
  logic [5:0] top;
  logic [3:0] idx;
  logic [6:0] mag;
  logic [7:0] nxt_dac;

  // Quarter-wave sine magnitude
  function automatic logic [6:0] quarter_sine(input logic [3:0] i);
    case (i)
      4'h0: quarter_sine = 7'h06;
      4'h1: quarter_sine = 7'h13;
      4'h2: quarter_sine = 7'h1F;
      4'h3: quarter_sine = 7'h2B;
      4'h4: quarter_sine = 7'h36;
      4'h5: quarter_sine = 7'h41;
      4'h6: quarter_sine = 7'h4C;
      4'h7: quarter_sine = 7'h55;
      4'h8: quarter_sine = 7'h5E;
      4'h9: quarter_sine = 7'h66;
      4'hA: quarter_sine = 7'h6D;
      4'hB: quarter_sine = 7'h73;
      4'hC: quarter_sine = 7'h78;
      4'hD: quarter_sine = 7'h7B;
      4'hE: quarter_sine = 7'h7E;
      default: quarter_sine = 7'h7F;
    endcase
  endfunction

  // Step picks tone; accumulator never jumps on a tone change
  assign inc = mark ? flm_pkg::INC_MARK : flm_pkg::INC_SPACE;
  assign top = phase_ff[23:18];
  assign idx = top[4] ? ~top[3:0] : top[3:0];
  assign mag = quarter_sine(idx);
  assign nxt_dac = top[5] ? (flm_pkg::DAC_MID - {1'b0, mag})
                          : (flm_pkg::DAC_MID + {1'b0, mag});

  // Accumulator and sample register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_ff <= 24'h000000;
      dac_code <= 8'h80;
    end else if (!enable) begin
      phase_ff <= 24'h000000;
      dac_code <= flm_pkg::DAC_MID;
    end else begin
      phase_ff <= phase_ff + inc;
      dac_code <= nxt_dac;
    end
  end

endmodule

// File: rtl/flm_modem.sv
// Half-duplex FSK loop modem core with register port
//
// Functional notes
// - Transmit-request high selects receive; low selects transmit.
// - Transmit makes a 1200 or 2200 Hz sine with continuous phase.
// - Logic one is the mark tone at 1.2 kHz; zero is space.
// - Receive recovers the bit stream from the tone input onto rx_data.
// - Carrier flag rises above 120 mVpp, falls below 80 mVpp.
// - Reset pin is an input and is pulled low on internal reset.
// - Clock select high uses external clock; low runs the crystal amplifier.
// - Reference enabled only in receive mode.
// - Only modulation and demodulation; framing left to the host.
// - Never transmit and receive together; host alternates direction.
// - Space tone 2.2 kHz; 1.2 kbps symbols of about 833 us.
// - Transmit tone follows tx_data level directly: high mark, low space.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
module flm_modem (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire flm_pkg::flm_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  output logic irq,
  input wire logic tx_request,
  input wire logic tx_data,
  output logic rx_data,
  output logic carrier_present,
  input wire logic [9:0] tone_in,
  output logic [7:0] tone_out,
  output logic ref_en,
  input wire logic ext_clock_select,
  output logic osc_amp_en,
  input wire logic supply_low,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Flip-flops
  logic [1:0] ctrl_ff;
  logic [4:0] mask_ff;
  logic [4:0] status_ff;
  logic [31:0] rdata_ff;
  logic [9:0] hold_cnt_ff;
  logic core_rst_q_ff;
  logic demod_q_ff;
  logic [10:0] div_ff;
  logic above_ff;
  logic [6:0] run_cnt_ff;
  logic bit_ff;
  logic [5:0] win_cnt_ff;
  logic [9:0] max_ff;
  logic [9:0] min_ff;
  logic [9:0] pp_ff;
  logic cd_ff;
  logic rx_q_ff;

  // Combinational nets
  logic demod;
  logic hold_active;
  logic core_rst;
  logic rx_run;
  logic sample_en;
  logic nxt_above;
  logic crossing;
  logic win_end;
  logic [9:0] nxt_max;
  logic [9:0] nxt_min;
  logic [9:0] win_pp;
  logic nxt_cd;
  logic [9:0] hyst_hi;
  logic [9:0] hyst_lo;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_status;
  logic [31:0] rd_mux;
  logic [4:0] events;
  logic [31:0] state_word;
  logic tone_enable;
  logic hit_ctrl;
  logic hit_status;
  logic hit_mask;
  logic hit_state;

  ////////////////////////////////////////////////////////////////////////////
  // Mode and analogue control pins

  // Direction comes straight from the host pin
  assign demod = tx_request;
  // Reference powered only while receiving
  assign ref_en = demod;
  // Crystal amplifier runs unless an external clock is fed in
  assign osc_amp_en = ~ext_clock_select;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin and internal reset

  // Internal reset causes stretch a low pulse on the pin
  // Pin only ever pulled low; the board pull-up makes the high
  assign hold_active = (hold_cnt_ff != 10'h000);
  assign rst_pin_oe = hold_active;
  assign rst_pin_out = 1'b0;
  // Pin read back also catches the board pulling it low
  assign core_rst = ~rst_pin_in | hold_active;

  // Stretch counter
  // A cause that lasts keeps reloading, so the pin stays low throughout
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold_cnt_ff <= 10'h000;
    end else if (supply_low | ctrl_ff[flm_pkg::CTRL_SOFT_RST]) begin
      hold_cnt_ff <= flm_pkg::RST_HOLD_CYC;
    end else if (hold_active) begin
      hold_cnt_ff <= hold_cnt_ff - 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path

  // Generator only runs in modulate mode
  // Mute and core reset also park the accumulator at zero phase
  assign tone_enable = ~demod & ~core_rst & ~ctrl_ff[flm_pkg::CTRL_MUTE];

  // Sine generator; tone step picked from the data level
  flm_tone_gen u_tone (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .enable(tone_enable),
    .mark(tx_data),
    .dac_code(tone_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Receive sampling

  // Receiver is held idle while transmitting
  // Core reset also stops it, so a reset never decodes noise
  assign rx_run = demod & ~core_rst;
  assign sample_en = rx_run & (div_ff == flm_pkg::SAMPLE_DIV - 11'h001);

  // Sample-rate divider
  // Restarts on entry to receive, so sample phase is repeatable
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_ff <= 11'h000;
    end else if (!rx_run || sample_en) begin
      div_ff <= 11'h000;
    end else begin
      div_ff <= div_ff + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero-crossing demodulator

  // Crossing thresholds around the input bias
  // Band keeps noise near the bias from faking crossings
  assign hyst_hi = flm_pkg::ADC_MID + flm_pkg::ZC_HYST;
  assign hyst_lo = flm_pkg::ADC_MID - flm_pkg::ZC_HYST;
  assign nxt_above = (tone_in > hyst_hi) ? 1'b1 :
                     (tone_in < hyst_lo) ? 1'b0 : above_ff;
  assign crossing = sample_en & (nxt_above != above_ff);

  // Half-period length decides mark or space
  // Run count saturates on a silent line instead of wrapping
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      above_ff <= 1'b0;
      run_cnt_ff <= 7'h00;
      bit_ff <= 1'b1;
    end else if (!rx_run) begin
      above_ff <= 1'b0;
      run_cnt_ff <= 7'h00;
      bit_ff <= 1'b1;
    end else if (crossing) begin
      above_ff <= nxt_above;
      run_cnt_ff <= 7'h00;
      bit_ff <= (run_cnt_ff > flm_pkg::BIT_SPLIT);
    end else if (sample_en && run_cnt_ff != flm_pkg::RUN_MAX) begin
      run_cnt_ff <= run_cnt_ff + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carrier detect

  // Window extremes including current sample
  assign win_end = sample_en & (win_cnt_ff == flm_pkg::CD_WIN);
  assign nxt_max = (tone_in > max_ff) ? tone_in : max_ff;
  assign nxt_min = (tone_in < min_ff) ? tone_in : min_ff;
  assign win_pp = nxt_max - nxt_min;
  // Two thresholds give hysteresis
  assign nxt_cd = cd_ff ? ~(win_pp < flm_pkg::CD_OFF_CNT)
                        : (win_pp > flm_pkg::CD_ON_CNT);

  // Peak-to-peak tracking per mark period
  // One window spans a mark period, so both tones show full swing
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      win_cnt_ff <= 6'h00;
      max_ff <= 10'h000;
      min_ff <= 10'h3FF;
    end else if (!rx_run || win_end) begin
      win_cnt_ff <= 6'h00;
      max_ff <= 10'h000;
      min_ff <= 10'h3FF;
    end else if (sample_en) begin
      win_cnt_ff <= win_cnt_ff + 6'h01;
      max_ff <= nxt_max;
      min_ff <= nxt_min;
    end
  end

  // Carrier flag and last amplitude
  // Flag moves only at window ends or when receive stops, and holds between them
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cd_ff <= 1'b0;
      pp_ff <= 10'h000;
    end else if (!rx_run) begin
      cd_ff <= 1'b0;
      pp_ff <= 10'h000;
    end else if (win_end) begin
      cd_ff <= nxt_cd;
      pp_ff <= win_pp;
    end
  end

  // Data pins idle while transmitting or without carrier
  // Idle high reads as a stop level to the host UART
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_data <= 1'b1;
      carrier_present <= 1'b0;
    end else begin
      rx_data <= ~(rx_run & cd_ff) | bit_ff;
      carrier_present <= rx_run & cd_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event sources

  // Edge history for event detection
  // History resets to idle levels so reset raises no false event
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      core_rst_q_ff <= 1'b0;
      demod_q_ff <= 1'b1;
      rx_q_ff <= 1'b1;
    end else begin
      core_rst_q_ff <= core_rst;
      demod_q_ff <= demod;
      rx_q_ff <= rx_data;
    end
  end

  // One pulse per event source
  assign events[flm_pkg::EV_CD_ON] = win_end & ~cd_ff & nxt_cd;
  assign events[flm_pkg::EV_CD_OFF] = win_end & cd_ff & ~nxt_cd;
  assign events[flm_pkg::EV_RX_EDGE] = rx_q_ff ^ rx_data;
  assign events[flm_pkg::EV_MODE] = demod_q_ff ^ demod;
  assign events[flm_pkg::EV_PIN_RST] = core_rst_q_ff & ~core_rst;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  // Address hits shared by strobes and read selection
  assign hit_ctrl = (bus_req.addr == flm_pkg::REG_CTRL);
  assign hit_status = (bus_req.addr == flm_pkg::REG_STATUS);
  assign hit_mask = (bus_req.addr == flm_pkg::REG_MASK);
  assign hit_state = (bus_req.addr == flm_pkg::REG_STATE);

  // Qualified strobes; writes to status and state fall away
  assign wr_ctrl = bus_req.wr & hit_ctrl;
  assign wr_mask = bus_req.wr & hit_mask;
  assign rd_status = bus_req.rd & hit_status;

  // Live state word: mode, carrier, rx, tx, clock select, last p-p
  assign state_word = {14'h0000, pp_ff, 3'h0, ext_clock_select, tx_data,
                       rx_data, carrier_present, demod};

  // Read selection; unmapped reads zero
  assign rd_mux = hit_ctrl ? {30'h00000000, ctrl_ff} :
                  hit_status ? {27'h0000000, status_ff} :
                  hit_mask ? {27'h0000000, mask_ff} :
                  hit_state ? state_word : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Control and mask; soft reset bit clears itself
  // Soft reset lasts one cycle; the stretch counter holds the pin
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= flm_pkg::CTRL_RESET;
      mask_ff <= flm_pkg::MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= bus_req.wdata[1:0];
      end else begin
        ctrl_ff[flm_pkg::CTRL_SOFT_RST] <= 1'b0;
      end
      if (wr_mask) begin
        mask_ff <= bus_req.wdata[4:0];
      end
    end
  end

  // Sticky status bits; a new event beats the read clear
  // An event in the clearing read cycle stays for the next read
  genvar gi;
  generate
    for (gi = 0; gi < flm_pkg::EV_N; gi++) begin : g_status
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          status_ff[gi] <= 1'b0;
        end else begin
          status_ff[gi] <= events[gi] | (status_ff[gi] & ~rd_status);
        end
      end
    end
  endgenerate

  // Read data valid only in the cycle after the strobe
  // Zero outside that slot, so an idle port reads quiet
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= bus_req.rd ? rd_mux : 32'h00000000;
    end
  end

  // Registered read data to the port
  assign bus_rdata = rdata_ff;
  // Level interrupt from unmasked status
  assign irq = |(status_ff & mask_ff);

endmodule

// File: verif/flm_modem_props.sv
// Port checker for the loop modem
`timescale 1ns/10ps
module flm_modem_props (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire flm_pkg::flm_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic irq,
  input wire logic tx_request,
  input wire logic tx_data,
  input wire logic rx_data,
  input wire logic carrier_present,
  input wire logic [9:0] tone_in,
  input wire logic [7:0] tone_out,
  input wire logic ref_en,
  input wire logic ext_clock_select,
  input wire logic osc_amp_en,
  input wire logic supply_low,
  input wire logic rst_pin_in,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  logic [9:0] since_low_ff;
  // Cycles since the supply came good
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      since_low_ff <= 10'h3FF;
    else if (supply_low)
      since_low_ff <= 10'h000;
    else if (since_low_ff != 10'h3FF)
      since_low_ff <= since_low_ff + 10'h001;
  end
  // Settled transmit and receive runs
  sequence s_tx_run;
    (!tx_request && rst_pin_in) [*4];
  endsequence
  sequence s_rx_run;
    tx_request [*3];
  endsequence
  a_ref_by_mode: assert property (ref_en == tx_request)
    else $error("reference enable does not follow mode");
  a_osc_by_sel: assert property (osc_amp_en == !ext_clock_select)
    else $error("oscillator amplifier enable wrong");
  a_tx_quiet_rx: assert property (s_tx_run |-> rx_data && !carrier_present)
    else $error("receive outputs active while transmitting");
  a_rx_quiet_tx: assert property (s_rx_run |-> tone_out == 8'h80)
    else $error("tone output active while receiving");
  // One cycle moves at most one table step, 13 codes at worst
  a_phase_smooth: assert property (s_tx_run |->
    8'(tone_out - $past(tone_out) + 8'h0D) <= 8'h1A)
    else $error("tone output jumped");
  a_pin_pull: assert property ($rose(supply_low) |=> rst_pin_oe && !rst_pin_in)
    else $error("reset pin not pulled on internal reset");
  a_pin_stretch: assert property (since_low_ff < 10'h3E0 |-> rst_pin_oe)
    else $error("reset pin released early");
  a_pin_level: assert property (rst_pin_oe |-> !rst_pin_out)
    else $error("reset pin driven high");
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule
bind flm_modem flm_modem_props i_props (.*);

// File: verif/flm_loop_model.sv
// Loop front end model feeding sampled tone to the modem
`timescale 1ns/10ps
module flm_loop_model (
  input wire logic ref_clk,
  input wire logic ref_en,
  input wire logic [11:0] freq_hz,
  input wire logic [9:0] amp_mv,
  output logic [9:0] tone_in
);
  real ph = 0.0;
  initial tone_in = 10'h200;
  // Biased sine while reference is up, floating line otherwise
  always @(posedge ref_clk) begin
    ph = ph + freq_hz * 1.0E-8;
    if (ph >= 1.0)
      ph = ph - 1.0;
    if (ref_en)
      tone_in <= 10'h200 + 10'($rtoi(amp_mv * 1024.0 / 2460.0 * $sin(6.2832 * ph)));
    else
      tone_in <= ~tone_in;
  end
endmodule

// File: verif/testbench.sv
// Self-checking bench for the loop modem
`timescale 1ns/10ps
module testbench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  flm_pkg::flm_bus_req_t bus_req = '0;
  logic [31:0] bus_rdata;
  logic [31:0] rd_word;
  logic [31:0] rnd;
  logic [10:0] frame;
  logic irq, rx_data, carrier_present, ref_en, osc_amp_en;
  logic rst_pin_out, rst_pin_oe, rst_pin_in;
  logic tx_request = 1'b1;
  logic tx_data = 1'b1;
  logic ext_clock_select = 1'b0;
  logic supply_low = 1'b0;
  logic ext_rst = 1'b0;
  logic [9:0] tone_in;
  logic [7:0] tone_out;
  logic [11:0] freq_hz = 12'h898;
  logic [9:0] amp_mv = 10'h0C8;
  int num_errors = 0;
  int checks_done = 0;
  int n_mark, n_space;
  always #5 ref_clk = ~ref_clk;
  // Pulled-up reset wire
  assign rst_pin_in = ~((rst_pin_oe & ~rst_pin_out) | ext_rst);
  // Compatibility strap is a board tie-high, outside the core
  flm_modem i_dut (.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .irq(irq), .tx_request(tx_request), .tx_data(tx_data), .rx_data(rx_data),
    .carrier_present(carrier_present), .tone_in(tone_in), .tone_out(tone_out),
    .ref_en(ref_en), .ext_clock_select(ext_clock_select), .osc_amp_en(osc_amp_en),
    .supply_low(supply_low), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe));
  flm_loop_model i_loop (.ref_clk(ref_clk), .ref_en(ref_en), .freq_hz(freq_hz),
    .amp_mv(amp_mv), .tone_in(tone_in));
  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus and wait helpers
  task automatic check1(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_near(string what, longint exp, longint got);
    checks_done++;
    if (got < exp - exp / 20 || got > exp + exp / 20) begin
      num_errors++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask
  // Host character, first bit at [0]: start, eight data, parity, stop
  function automatic logic [10:0] char_frame(logic [7:0] d);
    return {1'b1, ^d, d, 1'b0};
  endfunction
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(logic [7:0] a);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 rd_word = bus_rdata;
    @(posedge ref_clk);
  endtask
  task automatic wait_for(ref logic sig, input logic val, input int lim);
    int i;
    for (i = 0; i < lim && sig !== val; i++)
      @(posedge ref_clk);
    if (sig !== val) begin
      num_errors++;
      $display("unexpected wait end: expected %b seen %b", val, sig);
      wrap_up();
    end
  endtask
  // Cycles from tone start until output climbs 16 codes
  task automatic rise_time(input logic bit_v, output int n);
    tx_data <= bit_v;
    tx_request <= 1'b0;
    n = 0;
    while (tone_out < 8'h90 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 5000) begin
      num_errors++;
      $display("unexpected tone rise: expected under 5000 cycles seen %0d", n);
      wrap_up();
    end
    tx_request <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'hFAEB74AF));
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    check1("rx_data", 1, rx_data);
    check1("tone_out", 8'h80, tone_out);
    // Clock source select, both levels
    for (int v = 1; v >= 0; v--) begin
      ext_clock_select <= v[0];
      @(posedge ref_clk);
      #1 check1("osc_amp_en", !v[0], osc_amp_en);
    end
    $display("done: clock select");
    // Mask readback and unmapped read
    rnd = $urandom;
    wr(flm_pkg::REG_MASK, rnd);
    rd(flm_pkg::REG_MASK);
    check1("mask", {27'h0, rnd[4:0]}, rd_word);
    rd(8'h10);
    check1("unmapped", 32'h0, rd_word);
    // Mode change raises the interrupt, a status read clears it
    wr(flm_pkg::REG_MASK, 32'h1 << flm_pkg::EV_MODE);
    rd(flm_pkg::REG_STATUS);
    tx_request <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check1("irq", 1, irq);
    rd(flm_pkg::REG_STATUS);
    check1("mode event", 1, rd_word[flm_pkg::EV_MODE]);
    check1("irq", 0, irq);
    check1("ref_en", 0, ref_en);
    tx_request <= 1'b1;
    wr(flm_pkg::REG_MASK, 32'h0);
    // Muted transmit parks the output at midscale
    wr(flm_pkg::REG_CTRL, 32'h1 << flm_pkg::CTRL_MUTE);
    tx_request <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check1("muted tone", 8'h80, tone_out);
    tx_request <= 1'b1;
    wr(flm_pkg::REG_CTRL, 32'h0);
    $display("done: registers and interrupt");
    // Mark and space tones from the data level
    rise_time(1'b1, n_mark);
    rise_time(1'b0, n_space);
    check_near("tone ratio", n_space * flm_pkg::SPACE_HZ, n_mark * flm_pkg::MARK_HZ);
    check1("masked irq", 0, irq);
    $display("done: tone ratio");
    // Random host characters while sending, fast bit slots; phase kept smooth
    tx_request <= 1'b0;
    repeat (17) begin
      frame = char_frame(8'($urandom));
      for (int b = 0; b < 11; b++) begin
        tx_data <= frame[b];
        repeat (16) @(posedge ref_clk);
      end
    end
    check1("rx_data", 1, rx_data);
    check1("carrier", 0, carrier_present);
    ext_rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check1("tone in reset", 8'h80, tone_out);
    ext_rst <= 1'b0;
    $display("done: transmit");
    // Internal reset stretches the pin low
    supply_low <= 1'b1;
    @(posedge ref_clk);
    supply_low <= 1'b0;
    repeat (980) @(posedge ref_clk);
    check1("pin held", 1, rst_pin_oe);
    wait_for(rst_pin_oe, 1'b0, 60);
    wr(flm_pkg::REG_CTRL, 32'h1 << flm_pkg::CTRL_SOFT_RST);
    #1 check1("soft reset pin", 0, rst_pin_in);
    wait_for(rst_pin_oe, 1'b0, 1100);
    $display("done: reset pin");
    // Receive a space tone at 200 mVpp
    tx_request <= 1'b1;
    wait_for(carrier_present, 1'b1, 90000);
    rd(flm_pkg::REG_STATUS);
    check1("carrier on event", 1, rd_word[flm_pkg::EV_CD_ON]);
    wait_for(rx_data, 1'b0, 3000);
    tx_request <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check1("rx_data", 1, rx_data);
    check1("carrier", 0, carrier_present);
    $display("done: receive");
    wrap_up();
  end
endmodule
